//--- design/fcs_defs.svh
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define FCS_OFS_CTRL_ONE 6'h00
`define FCS_OFS_CTRL_TWO 6'h04
`define FCS_OFS_TRIM 6'h08
`define FCS_OFS_STATUS 6'h0C

// ****************************************
// reset values
// ****************************************
`define FCS_RST_CTRL_ONE 8'h04
`define FCS_RST_CTRL_TWO 8'h40
`define FCS_RST_TRIM 8'h80
`define FCS_RST_STATUS 8'h00

// ****************************************
// field positions and codes
// ****************************************
`define FCS_SRC_LOOP 2'h0
`define FCS_SRC_INT 2'h1
`define FCS_SRC_EXT 2'h2
`define FCS_SRC_NONE 2'h3
`define FCS_RANGE_RESERVED 2'h3
`define FCS_HIGH_RANGE_OFS 4'h5
`define FCS_REF_MAX_HIGH 3'h5
`define FCS_RESP_OKAY 2'h0
`define FCS_RESP_SLVERR 2'h2

`endif

//--- design/fcs_pkg.sv
package fcs_pkg;

	// ****************************************
	// register layouts
	// ****************************************
	typedef struct packed {
		logic [1:0] source_select;
		logic [2:0] reference_divider;
		logic reference_select;
		logic internal_reference_enable;
		logic internal_reference_stop_enable;
	} fcs_ctrl_one_t;

	typedef struct packed {
		logic [1:0] bus_divider;
		logic range;
		logic oscillator_gain;
		logic low_power_bypass;
		logic external_source_select;
		logic external_reference_enable;
		logic external_reference_stop_enable;
	} fcs_ctrl_two_t;

	typedef struct packed {
		logic [1:0] oscillator_range_select;
		logic max_frequency_tuning;
		logic reference_status;
		logic [1:0] clock_mode_status;
		logic oscillator_ready;
		logic fine_trim;
	} fcs_status_t;

	// ****************************************
	// operating modes
	// ****************************************
	typedef enum logic [6:0] {
		FCS_ENGAGED_INT = 7'b000_0001,
		FCS_ENGAGED_EXT = 7'b000_0010,
		FCS_BYPASS_INT = 7'b000_0100,
		FCS_BYPASS_INT_LO = 7'b000_1000,
		FCS_BYPASS_EXT = 7'b001_0000,
		FCS_BYPASS_EXT_LO = 7'b010_0000,
		FCS_STOP = 7'b100_0000
	} fcs_mode_t;

endpackage : fcs_pkg

//--- design/fcs_top.sv
// Function
// - seven modes: engaged int/ext, bypassed int/ext, both low power, stop
// - engaged internal is reset default: output from loop on internal reference, debug from loop
// - engaged external: output from loop on external reference, debug from loop
// - bypassed internal: loop runs on the ref picked by reference select, output from internal ref
// - bypassed internal low power: loop off, output internal ref, no debug clock
// - bypassed external: loop runs on the ref picked by reference select, output from external ref
// - bypassed external low power: loop off, output external ref, no debug clock
// - stop: loop off, no output or debug clock, references per config
// - leaving stop restarts loop oscillator from reset value for relock
// - source select 00 loop, 01 internal, 10 external, 11 as 00
// - reference divider: low range 2^n, high range 32..1024, reset zero
// - reference select 1 internal, 0 external for loop
// - internal enable gates internal reference onto its own output
// - internal reference kept in stop only if stop-enable and enable set
// - bus divider 1,2,4,8, resets to divide by 2
// - range bit drives oscillator high or low range
// - gain bit selects oscillator high gain or low power
// - low power bit stops loop in bypass unless debug active
// - external source select requests crystal or external clock
// - external enable gates external reference onto its own output
// - external source kept in stop only if stop-enable and enable set
// - bus clock is half the divided output clock
// - clock mode status follows the source actually in use, after sync
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"

module fcs_top
	import fcs_pkg::*;
#(
	parameter int ADDR_W = 6
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// clock sources from pins
	input wire logic int_ref_clk_i,
	input wire logic ext_ref_clk_i,
	input wire logic loop_clk_i,
	input wire logic osc_ready_i,
	// system state
	input wire logic stop_req_i,
	input wire logic debug_active_i,
	// clock outputs
	output logic divided_output_clock_o,
	output logic bus_clock_o,
	output logic debug_clock_o,
	output logic gated_internal_reference_clock_o,
	output logic gated_external_reference_clock_o,
	// loop control
	output logic loop_reference_clock_o,
	output logic loop_enable_o,
	output logic loop_restart_o,
	output logic [1:0] loop_range_o,
	output logic loop_max_tuning_o,
	output logic [8:0] trim_o,
	output logic internal_reference_run_o,
	// oscillator control
	output logic osc_range_o,
	output logic osc_gain_o,
	output logic osc_crystal_select_o,
	output logic osc_enable_o
);

	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta_reg, rst_n_reg;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [3:0] pin_meta_reg, pin_sync_reg;

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pin_meta_reg <= 4'h0;
			pin_sync_reg <= 4'h0;
		end else begin
			pin_meta_reg <= {osc_ready_i, loop_clk_i, ext_ref_clk_i, int_ref_clk_i};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	wire int_lvl = pin_sync_reg[0];
	wire ext_lvl = pin_sync_reg[1];
	wire loop_lvl = pin_sync_reg[2];
	wire osc_rdy_lvl = pin_sync_reg[3];

	// ****************************************
	// registers
	// ****************************************
	fcs_ctrl_one_t ctrl1_reg;
	fcs_ctrl_two_t ctrl2_reg;
	logic [7:0] trim_reg;
	logic [1:0] range_sel_reg;
	logic max_tune_reg, fine_trim_reg;
	logic ref_status_reg;
	logic [1:0] sel_cur_reg;
	fcs_mode_t mode_reg;

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;

	wire aw_fire = s_axi_awvalid_i & awready_reg;
	wire w_fire = s_axi_wvalid_i & wready_reg;
	wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire aw_full_next = (aw_full_reg | aw_fire) & ~do_write;
	wire w_full_next = (w_full_reg | w_fire) & ~do_write;
	wire ar_fire = s_axi_arvalid_i & arready_reg;
	wire rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready_i);
	wire wr_c1 = do_write & w_strb_reg & (aw_addr_reg == `FCS_OFS_CTRL_ONE);
	wire wr_c2 = do_write & w_strb_reg & (aw_addr_reg == `FCS_OFS_CTRL_TWO);
	wire wr_tr = do_write & w_strb_reg & (aw_addr_reg == `FCS_OFS_TRIM);
	wire wr_st = do_write & w_strb_reg & (aw_addr_reg == `FCS_OFS_STATUS);
	wire wr_hit = (aw_addr_reg == `FCS_OFS_CTRL_ONE) | (aw_addr_reg == `FCS_OFS_CTRL_TWO) |
		(aw_addr_reg == `FCS_OFS_TRIM) | (aw_addr_reg == `FCS_OFS_STATUS);
	wire rd_hit = (s_axi_araddr_i == `FCS_OFS_CTRL_ONE) | (s_axi_araddr_i == `FCS_OFS_CTRL_TWO) |
		(s_axi_araddr_i == `FCS_OFS_TRIM) | (s_axi_araddr_i == `FCS_OFS_STATUS);
	wire fcs_status_t status_now = '{oscillator_range_select: range_sel_reg,
		max_frequency_tuning: max_tune_reg, reference_status: ref_status_reg,
		clock_mode_status: sel_cur_reg, oscillator_ready: osc_rdy_lvl & ctrl2_reg.external_source_select,
		fine_trim: fine_trim_reg};
	wire [7:0] rd_byte = (s_axi_araddr_i == `FCS_OFS_CTRL_ONE) ? ctrl1_reg :
		(s_axi_araddr_i == `FCS_OFS_CTRL_TWO) ? ctrl2_reg :
		(s_axi_araddr_i == `FCS_OFS_TRIM) ? trim_reg :
		(s_axi_araddr_i == `FCS_OFS_STATUS) ? status_now : 8'h00;
	// range writes ignored when reserved or in low power
	wire range_wr_ok = (w_data_reg[7:6] != `FCS_RANGE_RESERVED) & ~ctrl2_reg.low_power_bypass;

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 8'h00;
			w_strb_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `FCS_RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= ~aw_full_next;
			wready_reg <= ~w_full_next;
			if (aw_fire) begin
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (w_fire) begin
				w_data_reg <= s_axi_wdata_i[7:0];
				w_strb_reg <= s_axi_wstrb_i[0];
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `FCS_RESP_OKAY;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_fire) begin
				rdata_reg <= {24'h00_0000, rd_byte};
				rresp_reg <= rd_hit ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl1_reg <= `FCS_RST_CTRL_ONE;
			ctrl2_reg <= `FCS_RST_CTRL_TWO;
			trim_reg <= `FCS_RST_TRIM;
			range_sel_reg <= 2'h0;
			max_tune_reg <= 1'b0;
			fine_trim_reg <= 1'b0;
		end else begin
			if (wr_c1) begin
				ctrl1_reg <= w_data_reg;
			end
			if (wr_c2) begin
				ctrl2_reg <= w_data_reg;
			end
			if (wr_tr) begin
				trim_reg <= w_data_reg;
			end
			if (wr_st) begin
				max_tune_reg <= w_data_reg[5];
				fine_trim_reg <= w_data_reg[0];
				if (range_wr_ok) begin
					range_sel_reg <= w_data_reg[7:6];
				end
			end
		end
	end

	// ****************************************
	// mode selection
	// ****************************************
	wire low_pwr = ctrl2_reg.low_power_bypass & ~debug_active_i;
	wire [1:0] src = ctrl1_reg.source_select;
	fcs_mode_t mode_next;
	always_comb begin
		case (1'b1)
			stop_req_i: mode_next = FCS_STOP;
			(src == `FCS_SRC_INT): mode_next = low_pwr ? FCS_BYPASS_INT_LO : FCS_BYPASS_INT;
			(src == `FCS_SRC_EXT): mode_next = low_pwr ? FCS_BYPASS_EXT_LO : FCS_BYPASS_EXT;
			default: mode_next = ctrl1_reg.reference_select ? FCS_ENGAGED_INT : FCS_ENGAGED_EXT;
		endcase
	end

	logic [1:0] sel_req;
	logic loop_on, debug_on;
	always_comb begin
		case (mode_reg)
			FCS_ENGAGED_INT, FCS_ENGAGED_EXT: begin
				sel_req = `FCS_SRC_LOOP;
				loop_on = 1'b1;
				debug_on = 1'b1;
			end
			FCS_BYPASS_INT: begin
				sel_req = `FCS_SRC_INT;
				loop_on = 1'b1;
				debug_on = 1'b1;
			end
			FCS_BYPASS_INT_LO: begin
				sel_req = `FCS_SRC_INT;
				loop_on = 1'b0;
				debug_on = 1'b0;
			end
			FCS_BYPASS_EXT: begin
				sel_req = `FCS_SRC_EXT;
				loop_on = 1'b1;
				debug_on = 1'b1;
			end
			FCS_BYPASS_EXT_LO: begin
				sel_req = `FCS_SRC_EXT;
				loop_on = 1'b0;
				debug_on = 1'b0;
			end
			default: begin
				sel_req = `FCS_SRC_NONE;
				loop_on = 1'b0;
				debug_on = 1'b0;
			end
		endcase
	end

	wire in_stop = (mode_reg == FCS_STOP);
	wire stop_entry = (mode_next == FCS_STOP) & ~in_stop;
	wire stop_exit = (mode_next != FCS_STOP) & in_stop;

	// ****************************************
	// glitch-free source switch
	// ****************************************
	wire cur_lvl = (sel_cur_reg == `FCS_SRC_LOOP) ? loop_lvl :
		(sel_cur_reg == `FCS_SRC_INT) ? int_lvl :
		(sel_cur_reg == `FCS_SRC_EXT) ? ext_lvl : 1'b0;
	wire req_lvl = (sel_req == `FCS_SRC_LOOP) ? loop_lvl :
		(sel_req == `FCS_SRC_INT) ? int_lvl :
		(sel_req == `FCS_SRC_EXT) ? ext_lvl : 1'b0;
	wire switch_ok = (sel_req != sel_cur_reg) & ~cur_lvl & ~req_lvl;

	// ****************************************
	// dividers
	// ****************************************
	logic cur_q_reg, loop_q_reg, ext_q_reg, div_out_reg, div_q_reg, bus_reg, dbg_reg;
	logic [2:0] div_cnt_reg;
	logic [9:0] ref_cnt_reg;
	wire [1:0] bsel = ctrl2_reg.bus_divider;
	wire div_next = (bsel == 2'h0) ? cur_lvl : div_cnt_reg[bsel - 2'h1];
	// reserved high-range codes clamp to the largest factor
	wire [2:0] rsel_eff = (ctrl2_reg.range & (ctrl1_reg.reference_divider > `FCS_REF_MAX_HIGH)) ?
		`FCS_REF_MAX_HIGH : ctrl1_reg.reference_divider;
	wire [3:0] ref_exp = {1'b0, rsel_eff} + (ctrl2_reg.range ? `FCS_HIGH_RANGE_OFS : 4'h0);
	wire ext_div = (ref_exp == 4'h0) ? ext_lvl : ref_cnt_reg[ref_exp - 4'h1];
	wire loop_ref_next = loop_on & (ref_status_reg ? int_lvl : ext_div);

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cur_q_reg <= 1'b0;
			div_cnt_reg <= 3'h0;
			div_out_reg <= 1'b0;
			div_q_reg <= 1'b0;
			bus_reg <= 1'b0;
		end else begin
			cur_q_reg <= cur_lvl;
			if (cur_lvl & ~cur_q_reg) begin
				div_cnt_reg <= div_cnt_reg + 3'h1;
			end
			div_out_reg <= (div_out_reg ^ div_q_reg) ? div_out_reg : div_next & ~in_stop;
			div_q_reg <= div_out_reg;
			if (div_out_reg & ~div_q_reg) begin
				bus_reg <= ~bus_reg;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			loop_q_reg <= 1'b0;
			ext_q_reg <= 1'b0;
			dbg_reg <= 1'b0;
			ref_cnt_reg <= 10'h000;
		end else begin
			loop_q_reg <= loop_lvl;
			ext_q_reg <= ext_lvl;
			if (!debug_on) begin
				dbg_reg <= 1'b0;
			end else if (loop_lvl & ~loop_q_reg) begin
				dbg_reg <= ~dbg_reg;
			end
			if (ext_lvl & ~ext_q_reg) begin
				ref_cnt_reg <= ref_cnt_reg + 10'h001;
			end
		end
	end

	// ****************************************
	// mode, status and stop handling
	// ****************************************
	logic irc_keep_reg, erc_keep_reg, restart_reg;

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mode_reg <= FCS_ENGAGED_INT;
			sel_cur_reg <= `FCS_SRC_LOOP;
			ref_status_reg <= 1'b1;
			irc_keep_reg <= 1'b0;
			erc_keep_reg <= 1'b0;
			restart_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			if (switch_ok) begin
				sel_cur_reg <= sel_req;
			end
			ref_status_reg <= ctrl1_reg.reference_select;
			if (stop_entry) begin
				irc_keep_reg <= ctrl1_reg.internal_reference_enable &
					ctrl1_reg.internal_reference_stop_enable;
				erc_keep_reg <= ctrl2_reg.external_reference_enable &
					ctrl2_reg.external_reference_stop_enable;
			end
			restart_reg <= stop_exit;
		end
	end

	// ****************************************
	// output stage
	// ****************************************
	wire int_run = ~in_stop | irc_keep_reg;
	wire ext_need = ctrl2_reg.external_reference_enable | ~ref_status_reg | (sel_req == `FCS_SRC_EXT);
	wire ext_run = in_stop ? erc_keep_reg : ext_need;

	always_ff @(posedge clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			gated_internal_reference_clock_o <= 1'b0;
			gated_external_reference_clock_o <= 1'b0;
			loop_reference_clock_o <= 1'b0;
			loop_enable_o <= 1'b0;
			internal_reference_run_o <= 1'b0;
			osc_range_o <= 1'b0;
			osc_gain_o <= 1'b0;
			osc_crystal_select_o <= 1'b0;
			osc_enable_o <= 1'b0;
			loop_range_o <= 2'h0;
			loop_max_tuning_o <= 1'b0;
			trim_o <= 9'h000;
		end else begin
			gated_internal_reference_clock_o <= ctrl1_reg.internal_reference_enable & int_lvl & int_run;
			gated_external_reference_clock_o <= ctrl2_reg.external_reference_enable & ext_lvl & ext_run;
			loop_reference_clock_o <= loop_ref_next;
			loop_enable_o <= loop_on;
			internal_reference_run_o <= int_run;
			osc_range_o <= ctrl2_reg.range;
			osc_gain_o <= ctrl2_reg.oscillator_gain;
			osc_crystal_select_o <= ctrl2_reg.external_source_select;
			osc_enable_o <= ext_run;
			loop_range_o <= range_sel_reg;
			loop_max_tuning_o <= max_tune_reg;
			trim_o <= {trim_reg, fine_trim_reg};
		end
	end

	assign divided_output_clock_o = div_out_reg;
	assign bus_clock_o = bus_reg;
	assign debug_clock_o = dbg_reg;
	assign loop_restart_o = restart_reg;
	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o = wready_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;

endmodule : fcs_top

`default_nettype wire

//--- test/fcs_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// reference sources and oscillator
// ****************************************
module fcs_osc_model (
	// control from block
	input wire logic osc_enable_i,
	input wire logic osc_crystal_select_i,
	input wire logic loop_enable_i,
	input wire logic int_run_i,
	// clocks to block
	output logic int_ref_clk_o,
	output logic ext_ref_clk_o,
	output logic loop_clk_o,
	output logic osc_ready_o
);
	logic ext_run;

	assign ext_run = osc_enable_i | !osc_crystal_select_i;

	initial begin
		int_ref_clk_o = 1'b0;
		forever #20 int_ref_clk_o = int_run_i ? !int_ref_clk_o : 1'b0;
	end

	initial begin
		ext_ref_clk_o = 1'b0;
		forever #28 ext_ref_clk_o = ext_run ? !ext_ref_clk_o : 1'b0;
	end

	initial begin
		loop_clk_o = 1'b0;
		forever #12 loop_clk_o = loop_enable_i ? !loop_clk_o : 1'b0;
	end

	initial begin
		osc_ready_o = 1'b0;
		forever begin
			@(osc_enable_i or osc_crystal_select_i);
			osc_ready_o = 1'b0;
			#201 osc_ready_o = osc_enable_i & osc_crystal_select_i;
		end
	end
endmodule : fcs_osc_model

`default_nettype wire

//--- test/fcs_props.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// port checker
// ****************************************
module fcs_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// register bus
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [1:0] s_axi_bresp_o,
	// clocks and loop
	input wire logic stop_req_i,
	input wire logic divided_output_clock_o,
	input wire logic bus_clock_o,
	input wire logic debug_clock_o,
	input wire logic loop_enable_o,
	input wire logic loop_restart_o,
	input wire logic loop_reference_clock_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_stop_held;
		stop_req_i [*4];
	endsequence

	sequence s_stop_exit;
		s_stop_held ##1 !stop_req_i;
	endsequence

	chk_stop_no_clock: assert property (s_stop_held |-> !divided_output_clock_o && !debug_clock_o)
		else $error("clock output seen in stop");
	chk_stop_loop_off: assert property (s_stop_held |-> !loop_enable_o)
		else $error("loop running in stop");
	chk_exit_restart: assert property (s_stop_exit |-> ##[0:3] loop_restart_o)
		else $error("no loop restart after stop");
	chk_restart_pulse: assert property (loop_restart_o |=> !loop_restart_o)
		else $error("loop restart longer than one cycle");
	chk_loop_off_quiet: assert property (!loop_enable_o [*3] |-> !debug_clock_o && !loop_reference_clock_o)
		else $error("debug or loop reference clock with loop off");
	chk_bus_half_rate: assert property (!divided_output_clock_o [*3] |-> $stable(bus_clock_o))
		else $error("bus clock moved without output clock edge");
	chk_no_runt_pulse: assert property ($changed(divided_output_clock_o) |=> $stable(divided_output_clock_o))
		else $error("runt pulse on output clock");
	chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	chk_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped");
	chk_write_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped");
endmodule : fcs_props

bind fcs_top fcs_props fcs_props_inst (.clk_i, .reset_n_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
	.s_axi_rready_i, .s_axi_rdata_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .stop_req_i,
	.divided_output_clock_o, .bus_clock_o, .debug_clock_o, .loop_enable_o, .loop_restart_o, .loop_reference_clock_o);

`default_nettype wire

//--- test/fll_clock_source_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module fll_clock_source_control_tb;
	logic clk_i, reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, stop_req_i, debug_active_i;
	logic [5:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic int_ref_clk_i, ext_ref_clk_i, loop_clk_i, osc_ready_i, divided_output_clock_o, bus_clock_o, debug_clock_o;
	logic gated_internal_reference_clock_o, gated_external_reference_clock_o, loop_reference_clock_o, loop_enable_o;
	logic loop_restart_o, internal_reference_run_o, osc_range_o, osc_gain_o, osc_crystal_select_o, osc_enable_o;
	logic [6:0] now_v;
	logic [6:0] prev = 7'h00;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	int seed, mdl[4], rises[7], cnt[7];
	logic [15:0] cfg [12] = '{16'h0400, 16'h0800, 16'h5630, 16'h4408, 16'h4408, 16'h8002, 16'h800E, 16'hC400,
		16'h4440, 16'h4480, 16'h44C0, 16'h1000}; // divided reference kept slow by divider choice

	fcs_top fcs_top_inst (.clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .int_ref_clk_i, .ext_ref_clk_i, .loop_clk_i, .osc_ready_i, .stop_req_i, .debug_active_i,
		.divided_output_clock_o, .bus_clock_o, .debug_clock_o, .gated_internal_reference_clock_o,
		.gated_external_reference_clock_o, .loop_reference_clock_o, .loop_enable_o, .loop_restart_o,
		.loop_range_o(), .loop_max_tuning_o(), .trim_o(), .internal_reference_run_o, .osc_range_o, .osc_gain_o,
		.osc_crystal_select_o, .osc_enable_o);

	fcs_osc_model fcs_osc_model_inst (.osc_enable_i(osc_enable_o), .osc_crystal_select_i(osc_crystal_select_o),
		.loop_enable_i(loop_enable_o), .int_run_i(internal_reference_run_o), .int_ref_clk_o(int_ref_clk_i),
		.ext_ref_clk_o(ext_ref_clk_i), .loop_clk_o(loop_clk_i), .osc_ready_o(osc_ready_i));

	// ****************************************
	// clock, edge counts and watchdog
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = !clk_i;
	end

	assign now_v = {loop_restart_o, loop_reference_clock_o, gated_external_reference_clock_o,
		gated_internal_reference_clock_o, debug_clock_o, bus_clock_o, divided_output_clock_o};

	always @(posedge clk_i) begin
		prev <= now_v;
		cycles++;
		for (int i = 0; i < 7; i++) begin
			if (now_v[i] && !prev[i]) rises[i]++;
		end
		if (cycles == 40000) begin
			failures++;
			summarize();
		end
	end

	// ****************************************
	// bus tasks and model
	// ****************************************
	function automatic logic near(input int g, input int e);
		return (g >= e - 2) && (g <= e + 2);
	endfunction : near

	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {24'h00_0000, d};
		s_axi_wstrb_i <= s;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		s_axi_bready_i <= 1'b0;
		`CHK("bresp", (a > 6'h0C) ? `FCS_RESP_SLVERR : `FCS_RESP_OKAY, s_axi_bresp_o)
		if (a <= 6'h0C && s[0]) mdl[a[3:2]] = d;
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b0;
		d = s_axi_rdata_o;
		`CHK("rresp", (a > 6'h0C) ? `FCS_RESP_SLVERR : `FCS_RESP_OKAY, s_axi_rresp_o)
	endtask : rd

	task automatic rchk(input logic [5:0] a);
		logic [31:0] d;
		rd(a, d);
		`CHK("reg", (a > 6'h08) ? 32'h0000_0000 : 32'(mdl[a[3:2]]), d)
	endtask : rchk

	task automatic chk_mode(input logic [1:0] m);
		logic [31:0] d;
		rd(`FCS_OFS_STATUS, d);
		`CHK("mode", m, d[3:2])
	endtask : chk_mode

	task automatic measure(input int n);
		int s[7];
		#1;
		s = rises;
		repeat (n) @(posedge clk_i);
		#1;
		foreach (cnt[i]) cnt[i] = rises[i] - s[i];
	endtask : measure

	// ****************************************
	// scenarios
	// ****************************************
	task automatic run_cfg(input logic [7:0] c1, input logic [7:0] c2, input logic da);
		int per;
		logic le;
		per = (c1[7:6] == 2'h1) ? 10 : (c1[7:6] == 2'h2) ? 14 : 6;
		le = c1[7:6] == 2'h0 || c1[7:6] == 2'h3 || !c2[3] || da;
		debug_active_i <= da;
		wr(`FCS_OFS_CTRL_ONE, c1, 4'hF);
		wr(`FCS_OFS_CTRL_TWO, c2, 4'hF);
		repeat (40) @(posedge clk_i);
		measure(800);
		chk_mode((c1[7:6] == 2'h3) ? 2'h0 : c1[7:6]);
		`CHK("div", 1'b1, near(cnt[0], 800 / (per << c2[7:6])))
		`CHK("bus", 1'b1, near(cnt[1], 400 / (per << c2[7:6])))
		`CHK("dbg", le, cnt[2] > 40)
		`CHK("loop_en", le, loop_enable_o)
		`CHK("irc", 1'b1, near(cnt[3], c1[1] ? 80 : 0))
		`CHK("erc", 1'b1, near(cnt[4], c2[1] ? 57 : 0))
		`CHK("lref", 1'b1, near(cnt[5], !le ? 0 : c1[2] ? 80 : 800 / (14 << c1[5:3])))
		`CHK("osc", {c2[5], c2[4], c2[2]}, {osc_range_o, osc_gain_o, osc_crystal_select_o})
	endtask : run_cfg

	task automatic run_stop(input logic [7:0] c1, input logic [7:0] c2, input logic keep);
		wr(`FCS_OFS_CTRL_ONE, c1, 4'hF);
		wr(`FCS_OFS_CTRL_TWO, c2, 4'hF);
		repeat (40) @(posedge clk_i);
		stop_req_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		measure(800);
		chk_mode(2'h3);
		`CHK("stop_clk", 0, cnt[0] + cnt[2])
		`CHK("stop_irc", 1'b1, near(cnt[3], keep ? 80 : 0))
		`CHK("stop_erc", 1'b1, near(cnt[4], keep ? 57 : 0))
		`CHK("stop_run", {keep, keep, 1'b0}, {internal_reference_run_o, osc_enable_o, loop_enable_o})
		@(posedge clk_i);
		stop_req_i <= 1'b0;
		measure(40);
		`CHK("restart", 1, cnt[6])
	endtask : run_stop

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	initial begin
		logic [5:0] a;
		seed = 28205;
		mdl = '{8'h04, 8'h40, 8'h80, 8'h00};
		{reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 6'h00;
		{stop_req_i, debug_active_i} = 2'h0;
		s_axi_awaddr_i = 6'h00;
		s_axi_araddr_i = 6'h00;
		s_axi_wdata_i = 32'h0000_0000;
		s_axi_wstrb_i = 4'h0;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 3; i++) rchk(6'(i * 4));
		chk_mode(2'h0);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			a = 6'(({$random(seed)} % 3) * 4);
			wr(a, 8'($random(seed)), 4'hF);
			rchk(a);
		end
		wr(`FCS_OFS_TRIM, 8'h33, 4'h0);
		rchk(`FCS_OFS_TRIM);
		wr(6'h10, 8'h5A, 4'hF);
		rchk(6'h10);
		$display("test register access done");
		for (int i = 0; i < 12; i++) begin
			run_cfg(cfg[i][15:8], cfg[i][7:0], i == 4);
			$display("test mode %0d done", i);
		end
		run_stop(8'h47, 8'h03, 1'b1);
		run_stop(8'h46, 8'h02, 1'b0);
		$display("test stop done");
		summarize();
	end
endmodule : fll_clock_source_control_tb

`default_nettype wire
